// [hdl/pin_mux_pkg.sv]
// Package with register map, field layouts and types of the pin drive and function mux.
`default_nettype none
package pin_mux_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] OFS_DRIVE_1 = 5'h00;
    localparam logic [4:0] OFS_DRIVE_2 = 5'h01;
    localparam logic [4:0] OFS_PA_FUNC_0 = 5'h02;
    localparam logic [4:0] OFS_PA_FUNC_1 = 5'h03;
    localparam logic [4:0] OFS_PB_FUNC_0 = 5'h04;
    localparam logic [4:0] OFS_PB_FUNC_1 = 5'h05;
    localparam logic [4:0] OFS_PC_FUNC_0 = 5'h06;
    localparam logic [4:0] OFS_PC_FUNC_1 = 5'h07;
    localparam logic [4:0] OFS_PD_FUNC_0 = 5'h08;
    localparam logic [4:0] OFS_PD_FUNC_1 = 5'h09;
    localparam logic [4:0] OFS_PE_FUNC_0 = 5'h0a;
    localparam logic [4:0] OFS_PE_FUNC_1 = 5'h0b;
    localparam logic [4:0] OFS_PF_FUNC_0 = 5'h0c;
    localparam logic [4:0] OFS_PF_FUNC_1 = 5'h0d;
    localparam logic [4:0] OFS_IN_SEL_0 = 5'h0e;
    localparam logic [4:0] OFS_IN_SEL_2 = 5'h0f;
    localparam logic [4:0] OFS_IN_SEL_3 = 5'h10;
    localparam logic [4:0] OFS_DIR_BASE = 5'h11;
    localparam int NUM_FUNC_REGS = 12;
    localparam int NUM_PORTS = 6;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_DIR = 8'hff;
    // Writable masks; unimplemented bits read zero and ignore writes.
    localparam logic [7:0] MASK_PA_FUNC_0 = 8'hcc;
    localparam logic [7:0] MASK_PB_FUNC_1 = 8'hf3;
    localparam logic [7:0] MASK_PD_FUNC_1 = 8'h3f;
    localparam logic [7:0] MASK_PE_FUNC_1 = 8'h03;
    localparam logic [7:0] MASK_IN_SEL_0 = 8'h7f;
    localparam logic [7:0] MASK_IN_SEL_2 = 8'h7f;
    localparam logic [7:0] MASK_IN_SEL_3 = 8'h03;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam int FLD_HI = 6;
    localparam int FLD_MID = 4;
    localparam int FLD_LO_MID = 2;
    localparam int FLD_LO = 0;
    localparam int PIN_A1_FLD = 2;
    localparam logic [1:0] FUNC_SLAVE_SEL = 2'h3;

    typedef enum logic [1:0] {
        LEVEL_0,
        LEVEL_1,
        LEVEL_2,
        LEVEL_3
    } drive_level_type;

    typedef struct packed {
        drive_level_type portd_low;
        drive_level_type portc_high;
        drive_level_type portc_low;
        drive_level_type portf_high;
        drive_level_type portf_low;
        drive_level_type porte_pin4;
        drive_level_type porte_rest;
    } drive_levels_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;
endpackage : pin_mux_pkg
`default_nettype wire

// [hdl/masked_reg.sv]
// One 8-bit software register with a writable-bit mask.
`timescale 1ns/1ps
`default_nettype none
module masked_reg #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] value
);
    logic [7:0] value_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            value_r <= RESET_VALUE & MASK;
        end else if (wr_en) begin
            value_r <= wdata & MASK;
        end
    end

    assign value = value_r;
endmodule // masked_reg
`default_nettype wire

// [hdl/pin_drive_and_function_mux.sv]
// Pin drive level and pin function select registers with decoded outputs.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pin_drive_and_function_mux #(
    parameter int PINS_PER_PORT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pin_mux_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pin_mux_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_in,
    input wire logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_out_data,
    output logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_oe,
    output logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_out,
    output pin_mux_pkg::drive_levels_type drive_levels,
    output logic [pin_mux_pkg::NUM_FUNC_REGS*8-1:0] func_select,
    output logic [23:0] input_select,
    output logic serial_slave_select,
    output logic external_interrupt_zero
);
    import pin_mux_pkg::*;

    // Port widths are fixed at eight pins, so any other count is refused.
    if (PINS_PER_PORT != 8) begin : g_bad_pins
        $error("pin_drive_and_function_mux supports only 8 pins per port");
    end

    reg_req_type req;
    logic [7:0] drive1_val;
    logic [7:0] drive2_val;
    logic [7:0] func_val [NUM_FUNC_REGS];
    logic [7:0] insel_val [3];
    logic [7:0] dir_val [NUM_PORTS];
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic [7:0] drive2_r;
    logic pin_a1_in;
    logic drive1_wr;
    logic drive2_wr;
    logic [NUM_FUNC_REGS-1:0] func_wr;
    logic [2:0] insel_wr;
    logic [NUM_PORTS-1:0] dir_wr;
    logic [1:0] pin_a1_code;
    logic pin_a1_is_slave;
    logic pin_a1_is_gpio;
    logic pin_a1_is_input;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    localparam logic [7:0] FUNC_MASKS [NUM_FUNC_REGS] = '{
        MASK_PA_FUNC_0, MASK_FULL, MASK_FULL, MASK_PB_FUNC_1,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_PD_FUNC_1,
        MASK_FULL, MASK_PE_FUNC_1, MASK_FULL, MASK_FULL};
    localparam logic [7:0] INSEL_MASKS [3] = '{MASK_IN_SEL_0, MASK_IN_SEL_2, MASK_IN_SEL_3};

    // Write decode gives one strobe per register and none for unmapped offsets.
    always_comb begin
        drive1_wr = 1'b0;
        drive2_wr = 1'b0;
        func_wr = '0;
        insel_wr = '0;
        dir_wr = '0;
        if (req.wr) begin
            case (req.addr)
                OFS_DRIVE_1: begin
                    drive1_wr = 1'b1;
                end
                OFS_DRIVE_2: begin
                    drive2_wr = 1'b1;
                end
                OFS_PA_FUNC_0: begin
                    func_wr[0] = 1'b1;
                end
                OFS_PA_FUNC_1: begin
                    func_wr[1] = 1'b1;
                end
                OFS_PB_FUNC_0: begin
                    func_wr[2] = 1'b1;
                end
                OFS_PB_FUNC_1: begin
                    func_wr[3] = 1'b1;
                end
                OFS_PC_FUNC_0: begin
                    func_wr[4] = 1'b1;
                end
                OFS_PC_FUNC_1: begin
                    func_wr[5] = 1'b1;
                end
                OFS_PD_FUNC_0: begin
                    func_wr[6] = 1'b1;
                end
                OFS_PD_FUNC_1: begin
                    func_wr[7] = 1'b1;
                end
                OFS_PE_FUNC_0: begin
                    func_wr[8] = 1'b1;
                end
                OFS_PE_FUNC_1: begin
                    func_wr[9] = 1'b1;
                end
                OFS_PF_FUNC_0: begin
                    func_wr[10] = 1'b1;
                end
                OFS_PF_FUNC_1: begin
                    func_wr[11] = 1'b1;
                end
                OFS_IN_SEL_0: begin
                    insel_wr[0] = 1'b1;
                end
                OFS_IN_SEL_2: begin
                    insel_wr[1] = 1'b1;
                end
                OFS_IN_SEL_3: begin
                    insel_wr[2] = 1'b1;
                end
                OFS_DIR_BASE: begin
                    dir_wr[0] = 1'b1;
                end
                OFS_DIR_BASE + 5'h01: begin
                    dir_wr[1] = 1'b1;
                end
                OFS_DIR_BASE + 5'h02: begin
                    dir_wr[2] = 1'b1;
                end
                OFS_DIR_BASE + 5'h03: begin
                    dir_wr[3] = 1'b1;
                end
                OFS_DIR_BASE + 5'h04: begin
                    dir_wr[4] = 1'b1;
                end
                OFS_DIR_BASE + 5'h05: begin
                    dir_wr[5] = 1'b1;
                end
                default: begin
                    dir_wr = '0;
                end
            endcase
        end
    end

    // Drive level register one holds the port C and port D fields.
    masked_reg #(.MASK(MASK_FULL), .RESET_VALUE(RESET_ZERO)) u_drive1 (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(drive1_wr),
        .wdata(req.wdata),
        .value(drive1_val)
    );

    // Drive level register two holds the port E and port F fields.
    // all bits writable, reset zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive2_r <= RESET_ZERO;
        end else if (drive2_wr) begin
            drive2_r <= req.wdata;
        end
    end
    assign drive2_val = drive2_r;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FUNC_REGS; gi++) begin : g_func
            masked_reg #(.MASK(FUNC_MASKS[gi]), .RESET_VALUE(RESET_ZERO)) u_func (
                .core_clk(core_clk),
                .rst(rst),
                .wr_en(func_wr[gi]),
                .wdata(req.wdata),
                .value(func_val[gi])
            );
            assign func_select[gi*8 +: 8] = func_val[gi];
        end
        for (gi = 0; gi < 3; gi++) begin : g_insel
            masked_reg #(.MASK(INSEL_MASKS[gi]), .RESET_VALUE(RESET_ZERO)) u_insel (
                .core_clk(core_clk),
                .rst(rst),
                .wr_en(insel_wr[gi]),
                .wdata(req.wdata),
                .value(insel_val[gi])
            );
            assign input_select[gi*8 +: 8] = insel_val[gi];
        end
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_dir
            masked_reg #(.MASK(MASK_FULL), .RESET_VALUE(RESET_DIR)) u_dir (
                .core_clk(core_clk),
                .rst(rst),
                .wr_en(dir_wr[gi]),
                .wdata(req.wdata),
                .value(dir_val[gi])
            );
            assign pin_oe[gi*8 +: 8] = ~dir_val[gi];
            assign pin_out[gi*8 +: 8] = pin_out_data[gi*8 +: 8];
        end
    endgenerate

    always_comb begin
        drive_levels.portd_low = drive_level_type'(drive1_val[FLD_MID +: 2]);
        drive_levels.portc_high = drive_level_type'(drive1_val[FLD_LO_MID +: 2]);
        drive_levels.portc_low = drive_level_type'(drive1_val[FLD_LO +: 2]);
        drive_levels.portf_high = drive_level_type'(drive2_val[FLD_HI +: 2]);
        drive_levels.portf_low = drive_level_type'(drive2_val[FLD_MID +: 2]);
        drive_levels.porte_pin4 = drive_level_type'(drive2_val[FLD_LO_MID +: 2]);
        drive_levels.porte_rest = drive_level_type'(drive2_val[FLD_LO +: 2]);
    end

    assign pin_a1_in = pin_in[1];
    assign pin_a1_code = func_val[0][PIN_A1_FLD +: 2];
    always_comb begin
        pin_a1_is_slave = 1'b0;
        pin_a1_is_gpio = 1'b0;
        case (pin_a1_code)
            FUNC_SLAVE_SEL: begin
                pin_a1_is_slave = 1'b1;
            end
            default: begin
                pin_a1_is_gpio = 1'b1;
            end
        endcase
    end
    assign pin_a1_is_input = dir_val[0][1];
    assign serial_slave_select = pin_a1_is_slave && pin_a1_in;
    assign external_interrupt_zero = pin_a1_is_gpio && pin_a1_is_input && pin_a1_in;

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rdata_nxt = 8'h00;
        case (req.addr)
            OFS_DRIVE_1: begin
                rdata_nxt = drive1_val;
            end
            OFS_DRIVE_2: begin
                rdata_nxt = drive2_val;
            end
            OFS_PA_FUNC_0: begin
                rdata_nxt = func_val[0];
            end
            OFS_PA_FUNC_1: begin
                rdata_nxt = func_val[1];
            end
            OFS_PB_FUNC_0: begin
                rdata_nxt = func_val[2];
            end
            OFS_PB_FUNC_1: begin
                rdata_nxt = func_val[3];
            end
            OFS_PC_FUNC_0: begin
                rdata_nxt = func_val[4];
            end
            OFS_PC_FUNC_1: begin
                rdata_nxt = func_val[5];
            end
            OFS_PD_FUNC_0: begin
                rdata_nxt = func_val[6];
            end
            OFS_PD_FUNC_1: begin
                rdata_nxt = func_val[7];
            end
            OFS_PE_FUNC_0: begin
                rdata_nxt = func_val[8];
            end
            OFS_PE_FUNC_1: begin
                rdata_nxt = func_val[9];
            end
            OFS_PF_FUNC_0: begin
                rdata_nxt = func_val[10];
            end
            OFS_PF_FUNC_1: begin
                rdata_nxt = func_val[11];
            end
            OFS_IN_SEL_0: begin
                rdata_nxt = insel_val[0];
            end
            OFS_IN_SEL_2: begin
                rdata_nxt = insel_val[1];
            end
            OFS_IN_SEL_3: begin
                rdata_nxt = insel_val[2];
            end
            OFS_DIR_BASE: begin
                rdata_nxt = dir_val[0];
            end
            OFS_DIR_BASE + 5'h01: begin
                rdata_nxt = dir_val[1];
            end
            OFS_DIR_BASE + 5'h02: begin
                rdata_nxt = dir_val[2];
            end
            OFS_DIR_BASE + 5'h03: begin
                rdata_nxt = dir_val[3];
            end
            OFS_DIR_BASE + 5'h04: begin
                rdata_nxt = dir_val[4];
            end
            OFS_DIR_BASE + 5'h05: begin
                rdata_nxt = dir_val[5];
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign reg_rdata = rdata_r;
endmodule // pin_drive_and_function_mux
`default_nettype wire

// [verification/pin_mux_props.sv]
// Checker of drive level, function select and direction behaviour.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_props #(
    parameter int PINS_PER_PORT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pin_mux_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pin_mux_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_oe,
    input wire pin_mux_pkg::drive_levels_type drive_levels,
    input wire logic [pin_mux_pkg::NUM_FUNC_REGS*8-1:0] func_select,
    input wire logic serial_slave_select,
    input wire logic [pin_mux_pkg::NUM_PORTS*8-1:0] pin_in,
    input wire logic external_interrupt_zero
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence wr_at(logic [4:0] ofs);
        reg_wr && reg_addr == ofs;
    endsequence
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data not zero outside a read answer");
    AST_PORTD_DRIVE: assert property (wr_at(OFS_DRIVE_1) |=>
        drive_levels.portd_low == $past(reg_wdata[5:4])) else $error("Port D drive wrong");
    AST_PORTC_DRIVE: assert property (wr_at(OFS_DRIVE_1) |=>
        {drive_levels.portc_high, drive_levels.portc_low} == $past(reg_wdata[3:0]))
        else $error("Port C drive wrong");
    AST_PORTF_DRIVE: assert property (wr_at(OFS_DRIVE_2) |=>
        {drive_levels.portf_high, drive_levels.portf_low} == $past(reg_wdata[7:4]))
        else $error("Port F drive wrong");
    AST_PORTE_DRIVE: assert property (wr_at(OFS_DRIVE_2) |=>
        {drive_levels.porte_pin4, drive_levels.porte_rest} == $past(reg_wdata[3:0]))
        else $error("Port E drive wrong");
    AST_LEVEL_HOLD: assert property (!reg_wr |=> $stable(drive_levels))
        else $error("Drive levels changed without a write");
    AST_PA0_WRITE: assert property (wr_at(OFS_PA_FUNC_0) |=>
        func_select[7:0] == ($past(reg_wdata) & 8'hcc)) else $error("Port A select wrong");
    AST_SLAVE_SEL: assert property (serial_slave_select ==
        (func_select[3:2] == 2'h3 && pin_in[1]))
        else $error("Slave select does not follow pin A1 field");
    AST_EXT_EXTERNAL_INTERRUPT_ZERO: assert property (external_interrupt_zero ==
        (func_select[3:2] != 2'h3 && !pin_oe[1] && pin_in[1]))
        else $error("Interrupt zero does not follow pin A1 field and direction");
    AST_DIR_OE: assert property (wr_at(OFS_DIR_BASE) |=>
        pin_oe[7:0] == ~$past(reg_wdata)) else $error("Output enable does not follow direction");
endmodule // pin_mux_props
bind pin_drive_and_function_mux pin_mux_props #(.PINS_PER_PORT(PINS_PER_PORT)) props_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_oe(pin_oe),
    .drive_levels(drive_levels), .func_select(func_select),
    .serial_slave_select(serial_slave_select), .pin_in(pin_in),
    .external_interrupt_zero(external_interrupt_zero));
`default_nettype wire

// [verification/pin_drive_and_function_mux_tb_top.sv]
// Self-checking testbench of the pin drive and function mux.
`timescale 1ns/1ps
`default_nettype none
module pin_drive_and_function_mux_tb_top;
    import pin_mux_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [47:0] pin_in = 48'h0;
    logic [47:0] pin_out_data = 48'h0;
    logic [47:0] pin_oe, pin_out;
    drive_levels_type drive_levels;
    logic [95:0] func_select;
    logic [23:0] input_select;
    logic serial_slave_select, external_interrupt_zero;
    int n_mismatch = 0;
    int total_checks = 0;
    pin_drive_and_function_mux dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out_data(pin_out_data), .pin_oe(pin_oe), .pin_out(pin_out),
        .drive_levels(drive_levels), .func_select(func_select), .input_select(input_select),
        .serial_slave_select(serial_slave_select),
        .external_interrupt_zero(external_interrupt_zero));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(input drive_levels_type got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: drive levels %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] ofs, input logic [7:0] val);
        @(posedge core_clk);
        reg_addr <= ofs;
        reg_wdata <= val;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [4:0] ofs, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= ofs;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_val(reg_rdata, exp);
    endtask
    function automatic logic [7:0] func_mask(input logic [4:0] ofs);
        case (ofs)
            5'h02: return 8'hcc;
            5'h05: return 8'hf3;
            5'h09: return 8'h3f;
            5'h0b, 5'h10: return 8'h03;
            5'h0e, 5'h0f: return 8'h7f;
            default: return 8'hff;
        endcase
    endfunction
    task automatic t_reset();
        chk_lvl(drive_levels, 14'h0000);
        chk_val(pin_oe[7:0], 8'h00);
        rd_chk(OFS_DRIVE_2, 8'h00);
        rd_chk(OFS_PA_FUNC_0, 8'h00);
        rd_chk(OFS_DIR_BASE, 8'hff);
    endtask
    task automatic t_drive();
        wr_reg(OFS_DRIVE_1, 8'h1b);
        chk_lvl(drive_levels, 14'h1b00);
        wr_reg(OFS_DRIVE_2, 8'he4);
        chk_lvl(drive_levels, 14'h1be4);
        rd_chk(OFS_DRIVE_2, 8'he4);
        rd_chk(OFS_DRIVE_1, 8'h1b);
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_DRIVE_2, {4{k[1:0]}});
            chk_lvl(drive_levels, {6'h1b, {4{k[1:0]}}});
        end
    endtask
    task automatic t_func();
        for (int r = 2; r < 17; r++) begin
            wr_reg(5'(r), 8'hff);
            rd_chk(5'(r), func_mask(5'(r)));
        end
        chk_val(func_select[31:24], 8'hf3);
        chk_val(input_select[15:8], 8'h7f);
        chk_val(input_select[23:16], 8'h03);
        @(posedge core_clk);
        pin_in <= 48'h0000_0000_0002;
        #1;
        chk_val({6'h00, serial_slave_select, external_interrupt_zero}, 8'h02);
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            pin_in <= 48'h0;
            wr_reg(OFS_PA_FUNC_0, {4'h0, k[1:0], 2'h0});
            @(posedge core_clk);
            pin_in <= 48'h0000_0000_0002;
            #1;
            chk_val({6'h00, serial_slave_select, external_interrupt_zero}, 8'h01);
        end
        wr_reg(5'h1f, 8'hff);
        rd_chk(5'h1f, 8'h00);
    endtask
    task automatic t_dir();
        @(posedge core_clk);
        pin_out_data <= 48'h0000_0000_00c3;
        pin_in <= 48'h0000_0000_0002;
        wr_reg(OFS_DIR_BASE, 8'h0e);
        chk_val(pin_oe[7:0], 8'hf1);
        rd_chk(OFS_DIR_BASE, 8'h0e);
        chk_val(pin_out[7:0], 8'hc3);
        chk_val({7'h00, external_interrupt_zero}, 8'h01);
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_drive();
        t_func();
        t_dir();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end
endmodule // pin_drive_and_function_mux_tb_top
`default_nettype wire
